// file: hw/rsc_cfg.svh
/*
  Constants of the reset source control block: register address, flag
  positions, reset values and timing counts.
  Assumes a 125 MHz system clock and an 8-bit register port.
*/
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// ==========================================================================
// Register address and flag positions
// ==========================================================================
`define RSC_REG_ADDR        8'hEF
`define RSC_BIT_PIN         0
`define RSC_BIT_POWER       1
`define RSC_BIT_CLK_LOSS    2
`define RSC_BIT_WATCHDOG    3
`define RSC_BIT_SOFTWARE    4
`define RSC_BIT_COMPARATOR  5
`define RSC_BIT_FLASH       6
`define RSC_BIT_USB         7

// ==========================================================================
// Reset values
// ==========================================================================
`define RSC_FLAGS_POR       8'h02
`define RSC_USER_CODE_LIMIT 16'h7BFF

// ==========================================================================
// Timing
// ==========================================================================
`define RSC_CLK_PERIOD_NS   8
`define RSC_CLK_LOSS_NS     500
`define RSC_CLK_LOSS_CYC \
  ((`RSC_CLK_LOSS_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_WDT_DIV         12
`define RSC_HOLD_CYCLES     16

`endif

// file: hw/rsc_pkg.sv
/*
  Types shared by the reset source control modules.
  Assumes nothing of its surroundings.
*/
package rsc_pkg;

  // ========================================================================
  // Sequencer state and flag vector
  // ========================================================================
  typedef enum logic [0:0] {
    RSC_RUN  = 1'b0,
    RSC_HOLD = 1'b1
  } rsc_state_type;

  typedef logic [7:0] rsc_flags_type;

endpackage

// file: hw/rsc_detect_if.sv
/*
  Interface between the sequencer and the clock-loss stall timer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps

interface rsc_detect_if;
  logic level;
  logic enable;
  logic timeout;

  modport mon (
    input  level,
    input  enable,
    output timeout
  );

  modport ctl (
    output level,
    output enable,
    input  timeout
  );
endinterface

// file: hw/rsc_stall_timer.sv
/*
  Stall timer: flags a timeout when the watched level has not changed for
  TIMEOUT consecutive clock cycles while enabled.
  Assumes the watched level is synchronous to clk.
*/
`timescale 1ns/100ps

module rsc_stall_timer #(
  parameter int TIMEOUT = 63
) (
  input wire logic   clk, // Clock.
  input wire logic   rst, // Asynchronous reset, active high.
  rsc_detect_if.mon  det  // Level, enable and timeout.
);

  localparam int CW = $clog2(TIMEOUT + 1);

  logic          last_q;
  logic [CW-1:0] cnt_q;
  logic          timeout_q;

  // ========================================================================
  // Level history
  // ========================================================================
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_q <= 1'b0;
    end else begin
      last_q <= det.level;
    end
  end

  // ========================================================================
  // Stall count
  // ========================================================================
  // Any edge of the watched clock restarts the count.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q     <= '0;
      timeout_q <= 1'b0;
    end else if (!det.enable || (det.level != last_q)) begin
      cnt_q     <= '0;
      timeout_q <= 1'b0;
    end else if (cnt_q == CW'(TIMEOUT - 1)) begin
      timeout_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  assign det.timeout = timeout_q;

endmodule

// file: hw/rsc_reset_ctrl.sv
/*
  Reset source control: gathers the reset sources, holds the system in
  reset, records the cause in an 8-bit register and restarts the watchdog
  prescaler after every reset.
  Assumes all inputs are synchronous to ref_clk, that rst is the power-on
  reset, and that the reset pin itself is driven only from outside.
*/
`timescale 1ns/100ps
`include "rsc_cfg.svh"

module rsc_reset_ctrl
  import rsc_pkg::*;
#(
  parameter int          HOLD_CYCLES = `RSC_HOLD_CYCLES,
  parameter int          CLK_LOSS    = `RSC_CLK_LOSS_CYC,
  parameter int          WDT_DIV     = `RSC_WDT_DIV,
  parameter logic [15:0] CODE_LIMIT  = `RSC_USER_CODE_LIMIT
) (
  input  wire logic        ref_clk,        // System clock, 125 MHz.
  input  wire logic        rst,            // Power-on reset, active high.
  input  wire logic        ext_reset_n,    // Reset pin level, active low.
  input  wire logic [7:0]  sfr_addr,       // Register address.
  input  wire logic        sfr_wr,         // Register write strobe.
  input  wire logic        sfr_rd,         // Register read strobe.
  input  wire logic [7:0]  sfr_wdata,      // Register write data.
  output logic      [7:0]  sfr_rdata,      // Register read data.
  input  wire logic        system_clock,   // Sampled level of clock.
  input  wire logic        supply_low,     // Supply monitor trips.
  input  wire logic        supply_mon_on,  // Supply monitor switched on.
  input  wire logic        cmp_below,      // Non-inverting below inverting.
  input  wire logic        wdt_overflow,   // Unserviced watchdog overflow.
  input  wire logic        wdt_disable,    // Software stops the watchdog.
  input  wire logic        flash_req,      // Flash access strobe.
  input  wire logic [15:0] flash_addr,     // Flash access address.
  input  wire logic        flash_modify,   // Access is write or erase.
  input  wire logic        flash_blocked,  // Security setting blocks it.
  input  wire logic        usb_bus_reset,  // Bus reset signalling seen.
  input  wire logic        usb_fc_enabled, // USB controller enabled.
  input  wire logic        vbus_level,     // VBUS detector level.
  output logic             system_reset,   // System reset, active high.
  output logic             wdt_enable,     // Watchdog function enabled.
  output logic             wdt_tick        // Watchdog clock enable pulse.
);

  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam int DW = $clog2(WDT_DIV + 1);

  rsc_detect_if  det ();

  rsc_state_type state_q;
  logic [HW-1:0] hold_q;
  rsc_flags_type cause_q;
  rsc_flags_type pend_q;
  rsc_flags_type pend_d;
  logic          clk_en_q;
  logic          cmp_en_q;
  logic          usb_en_q;
  logic          mon_sel_q;
  logic          vbus_q;
  logic          reset_q;
  logic [7:0]    rdata_q;
  logic          wdt_en_q;
  logic [DW-1:0] div_q;
  logic          tick_q;

  logic          reg_hit;
  logic          reg_write;
  logic          pin_src;
  logic          mon_src;
  logic          clk_src;
  logic          cmp_src;
  logic          wdt_src;
  logic          flash_src;
  logic          sw_src;
  logic          usb_src;
  logic          level_src;
  logic          any_src;
  logic          hold_done;
  logic          leave_hold;

  // ========================================================================
  // Clock-loss detector
  // ========================================================================
  assign det.level  = system_clock;
  assign det.enable = clk_en_q && (state_q == RSC_RUN);

  // The detector sleeps during reset so a stalled clock cannot retrigger.
  rsc_stall_timer #(
    .TIMEOUT (CLK_LOSS)
  ) u_stall (
    .clk (ref_clk),
    .rst (rst),
    .det (det)
  );

  // ========================================================================
  // Reset sources
  // ========================================================================
  assign reg_hit   = (sfr_addr == `RSC_REG_ADDR);
  assign reg_write = sfr_wr && reg_hit && (state_q == RSC_RUN);

  assign pin_src = !ext_reset_n;
  assign mon_src = mon_sel_q && supply_low;
  assign clk_src = det.timeout;
  assign cmp_src = cmp_en_q && cmp_below;
  assign wdt_src = wdt_en_q && wdt_overflow;
  assign sw_src  = reg_write && sfr_wdata[`RSC_BIT_SOFTWARE];

  always_comb begin
    flash_src = 1'b0;
    if (flash_req) begin
      if (flash_addr > CODE_LIMIT) begin
        flash_src = 1'b1;
      end
      if (flash_blocked) begin
        flash_src = 1'b1;
      end
      if (flash_modify && !supply_mon_on) begin
        flash_src = 1'b1;
      end
    end
  end

  // Bus reset counts only while the USB controller can see it.
  assign usb_src = usb_en_q &&
                   ((usb_bus_reset && usb_fc_enabled) ||
                    (vbus_level != vbus_q));

  // Level sources keep the system in reset for as long as they last.
  assign level_src = pin_src || mon_src || cmp_src;
  assign any_src   = level_src || clk_src || wdt_src || flash_src ||
                     sw_src || usb_src;

  // When sources coincide, the highest one names the cause.
  always_comb begin
    pend_d = '0;
    if (pin_src) begin
      pend_d[`RSC_BIT_PIN] = 1'b1;
    end else if (mon_src) begin
      pend_d[`RSC_BIT_POWER] = 1'b1;
    end else if (clk_src) begin
      pend_d[`RSC_BIT_CLK_LOSS] = 1'b1;
    end else if (cmp_src) begin
      pend_d[`RSC_BIT_COMPARATOR] = 1'b1;
    end else if (wdt_src) begin
      pend_d[`RSC_BIT_WATCHDOG] = 1'b1;
    end else if (flash_src) begin
      pend_d[`RSC_BIT_FLASH] = 1'b1;
    end else if (sw_src) begin
      pend_d[`RSC_BIT_SOFTWARE] = 1'b1;
    end else begin
      pend_d[`RSC_BIT_USB] = usb_src;
    end
  end

  // ========================================================================
  // VBUS edge history
  // ========================================================================
  // A change between two samples counts as one VBUS event.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      vbus_q <= 1'b0;
    end else begin
      vbus_q <= vbus_level;
    end
  end

  // ========================================================================
  // Reset sequencer
  // ========================================================================
  assign hold_done  = (hold_q == HW'(HOLD_CYCLES - 1));
  assign leave_hold = (state_q == RSC_HOLD) && hold_done && !level_src;

  // The system stays in reset at least the hold time, and as long as a
  // level source is still active after it.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= RSC_HOLD;
    end else begin
      case (state_q)
        RSC_RUN: begin
          if (any_src) begin
            state_q <= RSC_HOLD;
          end
        end
        RSC_HOLD: begin
          if (leave_hold) begin
            state_q <= RSC_RUN;
          end
        end
        default: begin
          state_q <= RSC_HOLD;
        end
      endcase
    end
  end

  // ========================================================================
  // Hold counter
  // ========================================================================
  // The count starts again from zero on every entry into reset.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hold_q <= '0;
    end else if (state_q != RSC_HOLD) begin
      hold_q <= '0;
    end else if (!hold_done) begin
      hold_q <= hold_q + HW'(1);
    end
  end

  // ========================================================================
  // Pending cause
  // ========================================================================
  // The cause is fixed on entry; events during reset do not change it.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pend_q <= `RSC_FLAGS_POR;
    end else if (state_q == RSC_RUN && any_src) begin
      pend_q <= pend_d;
    end
  end

  // ========================================================================
  // Reset output
  // ========================================================================
  // Only the core is held in reset; the pin has no driver here.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reset_q <= 1'b1;
    end else if (state_q == RSC_RUN) begin
      reset_q <= any_src;
    end else if (leave_hold) begin
      reset_q <= 1'b0;
    end else begin
      reset_q <= 1'b1;
    end
  end

  // ========================================================================
  // Cause flags
  // ========================================================================
  // Flags change only on leaving reset; the power flag drops with any
  // other cause because only the captured cause is loaded.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cause_q <= `RSC_FLAGS_POR;
    end else if (leave_hold) begin
      cause_q <= pend_q;
    end
  end

  // ========================================================================
  // Source enables
  // ========================================================================
  // Enables survive internal resets; monitor selection is set at power-on.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clk_en_q  <= 1'b0;
      cmp_en_q  <= 1'b0;
      usb_en_q  <= 1'b0;
      mon_sel_q <= 1'b1;
    end else if (reg_write) begin
      clk_en_q  <= sfr_wdata[`RSC_BIT_CLK_LOSS];
      cmp_en_q  <= sfr_wdata[`RSC_BIT_COMPARATOR];
      usb_en_q  <= sfr_wdata[`RSC_BIT_USB];
      mon_sel_q <= sfr_wdata[`RSC_BIT_POWER];
    end
  end

  // ========================================================================
  // Register read port
  // ========================================================================
  // Read data stands for one cycle and is zero otherwise.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (sfr_rd && reg_hit) begin
      rdata_q <= cause_q;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ========================================================================
  // Watchdog enable and prescaler
  // ========================================================================
  // Software may stop the watchdog only while the system runs.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wdt_en_q <= 1'b1;
    end else if (state_q == RSC_HOLD) begin
      wdt_en_q <= 1'b1;
    end else if (wdt_disable) begin
      wdt_en_q <= 1'b0;
    end
  end

  // The prescaler restarts with every reset so the first tick is aligned.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (state_q == RSC_HOLD || !wdt_en_q) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (div_q == DW'(WDT_DIV - 1)) begin
      div_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + DW'(1);
      tick_q <= 1'b0;
    end
  end

  // ========================================================================
  // Outputs
  // ========================================================================
  assign sfr_rdata    = rdata_q;
  assign system_reset = reset_q;
  assign wdt_enable   = wdt_en_q;
  assign wdt_tick     = tick_q;

endmodule

// file: tb/rsc_pin_model.sv
/*
  Outside circuitry on the reset pin: pulls it low for a set count.
  Assumes start is a one-cycle pulse synchronous to ref_clk.
*/
`timescale 1ns/100ps

module rsc_pin_model (
  input  wire logic       ref_clk,    // System clock.
  input  wire logic [7:0] low_cycles, // Cycles to hold the pin low.
  input  wire logic       start,      // Starts one low pulse.
  output logic            ext_reset_n // Pin level.
);
  // ========================================================================
  // Pin driver
  // ========================================================================
  logic [7:0] cnt_q = 8'h00;

  always @(posedge ref_clk) begin
    if (start) begin
      cnt_q <= low_cycles;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end

  // The pull-up sets the level whenever nothing drives the pin low.
  assign ext_reset_n = (cnt_q == 8'h00);
endmodule

// file: tb/rsc_reset_ctrl_sva.sv
/*
  Checker of the reset source control block at its ports.
  Assumes it is bound to the rsc_reset_ctrl top module.
*/
`timescale 1ns/100ps

module rsc_reset_ctrl_sva #(
  parameter logic [15:0] CODE_LIMIT = 16'h7BFF
) (
  input wire logic        ref_clk,        // Clock.
  input wire logic        rst,            // Power-on reset.
  input wire logic        ext_reset_n,    // Reset pin.
  input wire logic [7:0]  sfr_addr,       // Address.
  input wire logic        sfr_wr,         // Write strobe.
  input wire logic        sfr_rd,         // Read strobe.
  input wire logic [7:0]  sfr_wdata,      // Write data.
  input wire logic [7:0]  sfr_rdata,      // Read data.
  input wire logic        system_clock,   // Watched clock level.
  input wire logic        supply_low,     // Monitor trips.
  input wire logic        supply_mon_on,  // Monitor on.
  input wire logic        cmp_below,      // Comparator low.
  input wire logic        wdt_overflow,   // Watchdog overflow.
  input wire logic        wdt_disable,    // Watchdog stop.
  input wire logic        flash_req,      // Flash strobe.
  input wire logic [15:0] flash_addr,     // Flash address.
  input wire logic        flash_modify,   // Write or erase.
  input wire logic        flash_blocked,  // Security block.
  input wire logic        usb_bus_reset,  // Bus reset.
  input wire logic        usb_fc_enabled, // USB enabled.
  input wire logic        vbus_level,     // VBUS level.
  input wire logic        system_reset,   // Reset out.
  input wire logic        wdt_enable,     // Watchdog on.
  input wire logic        wdt_tick        // Watchdog tick.
);
  // ========================================================================
  // Properties
  // ========================================================================
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic run;
  logic hit;
  assign run = !system_reset;
  assign hit = (sfr_addr == 8'hEF);

  chk_pin_holds: assert property (
    !ext_reset_n |=> system_reset) else $error("pin low without reset");
  chk_sw_force: assert property (
    run && sfr_wr && hit && sfr_wdata[4] |=> system_reset)
    else $error("software force ignored");
  chk_wdt_reset: assert property (
    run && wdt_overflow |=> system_reset) else $error("overflow ignored");
  chk_flash_limit: assert property (
    run && flash_req && (flash_addr > CODE_LIMIT) |=> system_reset)
    else $error("access above limit ignored");
  chk_flash_secure: assert property (
    run && flash_req && flash_blocked |=> system_reset)
    else $error("blocked access ignored");
  chk_flash_supply: assert property (
    run && flash_req && flash_modify && !supply_mon_on |=> system_reset)
    else $error("write without monitor ignored");
  chk_wdt_restart: assert property (
    $fell(system_reset) |-> wdt_enable ##[1:12] (wdt_tick || system_reset))
    else $error("watchdog not restarted");
  chk_tick_gap: assert property (
    wdt_tick |=> !wdt_tick [*8]) else $error("tick too early");
  chk_read_onehot: assert property (
    sfr_rd && hit |=> $onehot(sfr_rdata)) else $error("cause not one-hot");
  chk_read_idle: assert property (
    !sfr_rd || !hit |=> sfr_rdata == 8'h00) else $error("stray read data");

  cover property ($fell(system_reset));
  cover property (run && flash_req);
  cover property (sfr_rd && hit);
endmodule

bind rsc_reset_ctrl rsc_reset_ctrl_sva #(.CODE_LIMIT(CODE_LIMIT))
  rsc_reset_ctrl_sva_i (
  .ref_clk, .rst, .ext_reset_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
  .sfr_rdata, .system_clock, .supply_low, .supply_mon_on, .cmp_below,
  .wdt_overflow, .wdt_disable, .flash_req, .flash_addr, .flash_modify,
  .flash_blocked, .usb_bus_reset, .usb_fc_enabled, .vbus_level,
  .system_reset, .wdt_enable, .wdt_tick);

// file: tb/rsc_reset_ctrl_bench.sv
/*
  Self-checking bench of the reset source control block.
  Assumes the design package and interface are compiled before it.
*/
`timescale 1ns/100ps

module rsc_reset_ctrl_bench;
  // ========================================================================
  // Signals and helpers
  // ========================================================================
  logic ref_clk = 1'b0, rst = 1'b1, ext_reset_n, pin_start = 1'b0;
  logic [7:0] sfr_addr = 8'hEF, sfr_wdata = 8'h00, sfr_rdata;
  logic [7:0] pin_len = 8'h14, stall_n = 8'h00;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, system_clock = 1'b0;
  logic supply_low = 1'b0, supply_mon_on = 1'b1, cmp_below = 1'b0;
  logic wdt_overflow = 1'b0, wdt_disable = 1'b0, flash_req = 1'b0;
  logic [15:0] flash_addr = 16'h0000;
  logic flash_modify = 1'b0, flash_blocked = 1'b0, usb_bus_reset = 1'b0;
  logic usb_fc_enabled = 1'b0, vbus_level = 1'b0;
  logic system_reset, wdt_enable, wdt_tick;
  int   err_total = 0, checks_done = 0, cycles = 0;
  logic [2:0] blk = 3'b010, mdf = 3'b100, mon = 3'b011;

  always #4 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (stall_n != 8'h00) begin
      stall_n <= stall_n - 8'h01;
    end else begin
      system_clock <= ~system_clock;
    end
  end

  rsc_pin_model rsc_pin_model_i (.ref_clk(ref_clk), .low_cycles(pin_len),
    .start(pin_start), .ext_reset_n(ext_reset_n));

  rsc_reset_ctrl #(.HOLD_CYCLES(2), .CLK_LOSS(4)) rsc_reset_ctrl_i (
    .ref_clk(ref_clk), .rst(rst), .ext_reset_n(ext_reset_n),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .system_clock(system_clock), .supply_low(supply_low),
    .supply_mon_on(supply_mon_on), .cmp_below(cmp_below),
    .wdt_overflow(wdt_overflow), .wdt_disable(wdt_disable),
    .flash_req(flash_req), .flash_addr(flash_addr),
    .flash_modify(flash_modify), .flash_blocked(flash_blocked),
    .usb_bus_reset(usb_bus_reset), .usb_fc_enabled(usb_fc_enabled),
    .vbus_level(vbus_level), .system_reset(system_reset),
    .wdt_enable(wdt_enable), .wdt_tick(wdt_tick));

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      results();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Whole-byte write: the register is never read back and modified.
  task automatic wr(input logic [7:0] d);
    @(posedge ref_clk);
    sfr_wr <= 1'b1;
    sfr_wdata <= d;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    sfr_addr <= 8'hEF;
    #1 v = sfr_rdata;
    @(posedge ref_clk);
  endtask

  // Waits for a reset to start and end, then reads the cause flags.
  task automatic expect_reset(input logic [7:0] flags);
    logic [7:0] v;
    int n;
    n = 0;
    #1;
    while (system_reset !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1 n++;
    end
    check({7'h00, system_reset}, 8'h01);
    while (system_reset !== 1'b0 && n < 300) begin
      @(posedge ref_clk);
      #1 n++;
    end
    check({7'h00, wdt_enable}, 8'h01);
    rd(8'hEF, v);
    check(v, flags);
  endtask

  // ========================================================================
  // Test sequence
  // ========================================================================
  initial begin
    logic [7:0] v;
    tick(8);
    rst <= 1'b0;
    expect_reset(8'h02);
    rd(8'hEE, v);
    check(v, 8'h00);
    pin_start <= 1'b1;
    @(posedge ref_clk);
    pin_start <= 1'b0;
    expect_reset(8'h01);
    wdt_overflow <= 1'b1;
    @(posedge ref_clk);
    wdt_overflow <= 1'b0;
    expect_reset(8'h08);
    tick(8);
    #1 check({7'h00, wdt_tick}, 8'h00);
    tick(1);
    #1 check({7'h00, wdt_tick}, 8'h01);
    tick(3);
    wdt_disable <= 1'b1;
    @(posedge ref_clk);
    wdt_disable <= 1'b0;
    tick(1);
    #1 check({7'h00, wdt_enable}, 8'h00);
    wr(8'h10);
    expect_reset(8'h10);
    flash_req <= 1'b1;
    flash_addr <= 16'h7BFF;
    flash_modify <= 1'b1;
    @(posedge ref_clk);
    flash_req <= 1'b0;
    tick(2);
    #1 check({7'h00, system_reset}, 8'h00);
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      flash_req <= 1'b1;
      flash_addr <= (i == 0) ? 16'h7C00 : 16'h0100;
      flash_blocked <= blk[i];
      flash_modify <= mdf[i];
      supply_mon_on <= mon[i];
      @(posedge ref_clk);
      flash_req <= 1'b0;
      supply_mon_on <= 1'b1;
      expect_reset(8'h40);
    end
    wr(8'h04);
    stall_n <= 8'h0A;
    expect_reset(8'h04);
    wr(8'h00);
    stall_n <= 8'h0A;
    supply_low <= 1'b1;
    tick(12);
    supply_low <= 1'b0;
    #1 check({7'h00, system_reset}, 8'h00);
    wr(8'h02);
    wr(8'h12);
    expect_reset(8'h10);
    supply_low <= 1'b1;
    tick(3);
    supply_low <= 1'b0;
    expect_reset(8'h02);
    wr(8'h20);
    cmp_below <= 1'b1;
    tick(3);
    cmp_below <= 1'b0;
    expect_reset(8'h20);
    wr(8'h80);
    vbus_level <= 1'b1;
    expect_reset(8'h80);
    usb_fc_enabled <= 1'b1;
    usb_bus_reset <= 1'b1;
    @(posedge ref_clk);
    usb_bus_reset <= 1'b0;
    expect_reset(8'h80);
    results();
  end
endmodule
